// file: verilog/eflg_top.sv
// Event status flags 4..1 with wake/sleep control behind an AXI4-Lite slave
//
// Operation
// - Status bit 4 copies the outside-threshold event-active flag.
// - With outside latching on, bit 4 clears on reading source one, else when the event ends.
// - Status bit 3 copies the within-threshold event-active flag.
// - With within latching on, bit 3 clears on reading source two, else when the event ends.
// - Bit 2 sets when the new-orientation indicator comes with an orientation change.
// - Reading the orientation status register clears bit 2.
// - Bit 1 sets on any wake/sleep transition and stays clear otherwise.
// - The system state register shows the direction of the last transition.
// - Sleep is entered after the inactivity count of data periods with no event.
// - In sleep the sleep power, rate or flexible settings are applied.
// - In wake the wake power, rate or flexible settings are applied.
// - Reading the system state register clears bit 1.
// - A zero inactivity count disables the wake/sleep function and its flag.
// - Bit 1 works only while its interrupt enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "eflg_defines.svh"
module eflg_top
#(
	// Width of the inactivity count; the core counter serves 16 bits only
	parameter int COUNT_W = 16
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// Event sources
	input wire logic outside_event_active,
	input wire logic within_event_active,
	input wire logic new_orientation_indicator,
	input wire logic orient_change,
	input wire logic odr_tick,
	input wire logic any_event,
	// Wake and sleep settings
	input wire eflg_pkg::eflg_perf_t perf_cfg,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Applied operating settings and interrupt
	output logic [1:0] power_setting,
	output logic [3:0] output_data_rate,
	output logic [3:0] decim_setting,
	output logic [3:0] idle_setting,
	output logic sleep_active,
	output logic irq
);
	eflg_read_if rif ();
	logic [31:0] ctrl_reg;
	logic [15:0] count_reg;
	logic [4:0] irq_reg;
	logic [4:0] mask_reg;
	logic [7:0] awa_reg;
	logic [31:0] wd_reg;
	logic [3:0] ws_reg;
	logic aw_ok;
	logic w_ok;
	logic wr_go;
	logic rd_go;
	logic [4:0] stat;
	logic [4:0] stat_d_reg;
	logic [4:0] rise;
	logic [31:0] ctrl_wr;
	logic [31:0] count_wr;
	logic [31:0] mask_wr;

	// Refuse widths that the core counter cannot serve
	if (COUNT_W != 16)
	begin : g_count_w
		$error("inactivity count width must be 16");
	end

	// Byte-lane merge of a write into a register image
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction

	// Mapped word offsets answer OKAY
	function automatic logic known(input logic [7:0] a);
		return (a <= `EFLG_OFF_IRQMASK) && (a[1:0] == 2'b00);
	endfunction

	eflg_core u_core
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.outside_event_active(outside_event_active),
		.within_event_active(within_event_active),
		.new_orientation_indicator(new_orientation_indicator),
		.orient_change(orient_change),
		.odr_tick(odr_tick),
		.any_event(any_event),
		.outside_event_latch_enable(ctrl_reg[`EFLG_CTRL_OUTSIDE_EVENT_LATCH_ENABLE]),
		.within_event_latch_enable(ctrl_reg[`EFLG_CTRL_WITHIN_EVENT_LATCH_ENABLE]),
		.wake_sleep_interrupt_enable(ctrl_reg[`EFLG_CTRL_AS_EN]),
		.inactivity_count(count_reg),
		.rif(rif.core)
	);

	// Live status word, flags at bits 4 to 1
	always_comb
	begin
		stat = 5'h00;
		stat[`EFLG_BIT_OT] = rif.outside_threshold_event_flag;
		stat[`EFLG_BIT_WT] = rif.within_threshold_event_flag;
		stat[`EFLG_BIT_OR] = rif.orientation_change_flag;
		stat[`EFLG_BIT_AS] = rif.wake_sleep_transition_flag;
	end
	// Sticky bits follow only a flag's rising edge
	assign rise = stat & ~stat_d_reg;

	// Byte-lane images of the writable registers
	assign ctrl_wr = merge(ctrl_reg, wd_reg, ws_reg);
	assign count_wr = merge({16'h0000, count_reg}, wd_reg, ws_reg);
	assign mask_wr = merge({27'h0, mask_reg}, wd_reg, ws_reg);

	// Write channel capture, either order
	assign wr_go = aw_ok && w_ok && !s_axi_bvalid;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `EFLG_RESP_OKAY;
		end
		else if (ce)
		begin
			// Each ready pulses once per item, never while an item is held
			s_axi_awready <= !aw_ok && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_ok && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok <= 1'b1;
				awa_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok <= 1'b1;
				wd_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known(awa_reg) ? `EFLG_RESP_OKAY : `EFLG_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Software settings
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_reg <= `EFLG_CTRL_RESET;
			count_reg <= `EFLG_COUNT_RESET;
			mask_reg <= 5'h00;
		end
		else if (ce && wr_go)
		begin
			// Read-only and unmapped offsets ignore writes
			case (awa_reg)
				`EFLG_OFF_CTRL: ctrl_reg <= ctrl_wr & 32'h0000_000F;
				`EFLG_OFF_COUNT: count_reg <= count_wr[15:0];
				`EFLG_OFF_IRQMASK: mask_reg <= mask_wr[4:0];
				default: ;
			endcase
		end
	end

	// Sticky interrupt status, set wins over write-one clear
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_reg <= 5'h00;
			stat_d_reg <= 5'h00;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			stat_d_reg <= stat;
			if (wr_go && awa_reg == `EFLG_OFF_IRQ && ws_reg[0])
				irq_reg <= (irq_reg & ~wd_reg[4:0]) | rise;
			else
				irq_reg <= irq_reg | rise;
			// Interrupt follows the sticky bits one cycle later
			irq <= |(irq_reg & mask_reg);
		end
	end

	// Read channel with clear-on-read strobes
	assign rd_go = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `EFLG_RESP_OKAY;
		end
		else if (ce)
		begin
			// No new address is taken while read data waits
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= known(s_axi_araddr) ? `EFLG_RESP_OKAY : `EFLG_RESP_SLVERR;
				case (s_axi_araddr)
					`EFLG_OFF_STATUS: s_axi_rdata <= {27'h0, stat};
					`EFLG_OFF_MASK: s_axi_rdata <= {27'h0, mask_reg};
					`EFLG_OFF_CTRL: s_axi_rdata <= ctrl_reg;
					`EFLG_OFF_COUNT: s_axi_rdata <= {16'h0000, count_reg};
					`EFLG_OFF_SRC1: s_axi_rdata <= {31'h0, rif.outside_threshold_event_flag};
					`EFLG_OFF_SRC2: s_axi_rdata <= {31'h0, rif.within_threshold_event_flag};
					`EFLG_OFF_ORIENT: s_axi_rdata <= {31'h0, rif.orientation_change_flag};
					`EFLG_OFF_SYSMODE: s_axi_rdata <= {30'h0, rif.last_to_sleep, rif.sleep_now};
					`EFLG_OFF_IRQ: s_axi_rdata <= {27'h0, irq_reg};
					`EFLG_OFF_IRQMASK: s_axi_rdata <= {27'h0, mask_reg};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	assign rif.rd_src1 = ce && rd_go && s_axi_araddr == `EFLG_OFF_SRC1;
	assign rif.rd_src2 = ce && rd_go && s_axi_araddr == `EFLG_OFF_SRC2;
	assign rif.rd_orient = ce && rd_go && s_axi_araddr == `EFLG_OFF_ORIENT;
	assign rif.rd_sysmode = ce && rd_go && s_axi_araddr == `EFLG_OFF_SYSMODE;

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			power_setting <= 2'h0;
			output_data_rate <= 4'h0;
			decim_setting <= 4'h0;
			idle_setting <= 4'h0;
			sleep_active <= 1'b0;
		end
		else if (ce)
		begin
			sleep_active <= rif.sleep_now;
			power_setting <= rif.sleep_now ? perf_cfg.sleep_power_setting
				: perf_cfg.wake_power_setting;
			output_data_rate <= rif.sleep_now ? perf_cfg.sleep_odr : perf_cfg.wake_odr;
			// Decimation and idle time apply only in flexible mode
			if (ctrl_reg[`EFLG_CTRL_FLEX])
			begin
				decim_setting <= rif.sleep_now ? perf_cfg.sleep_decim : perf_cfg.wake_decim;
				idle_setting <= rif.sleep_now ? perf_cfg.sleep_idle : perf_cfg.wake_idle;
			end
		end
	end
endmodule
`default_nettype wire

// file: verilog/eflg_defines.svh
// Register offsets, field positions, reset values and response codes of the event flag block
`ifndef EFLG_DEFINES_SVH
`define EFLG_DEFINES_SVH
`define EFLG_OFF_STATUS 8'h00
`define EFLG_OFF_MASK 8'h04
`define EFLG_OFF_CTRL 8'h08
`define EFLG_OFF_COUNT 8'h0C
`define EFLG_OFF_SRC1 8'h10
`define EFLG_OFF_SRC2 8'h14
`define EFLG_OFF_ORIENT 8'h18
`define EFLG_OFF_SYSMODE 8'h1C
`define EFLG_OFF_IRQ 8'h20
`define EFLG_OFF_IRQMASK 8'h24
`define EFLG_BIT_OT 4
`define EFLG_BIT_WT 3
`define EFLG_BIT_OR 2
`define EFLG_BIT_AS 1
`define EFLG_CTRL_OUTSIDE_EVENT_LATCH_ENABLE 0
`define EFLG_CTRL_WITHIN_EVENT_LATCH_ENABLE 1
`define EFLG_CTRL_AS_EN 2
`define EFLG_CTRL_FLEX 3
`define EFLG_CTRL_RESET 32'h0000_0000
`define EFLG_COUNT_RESET 16'h0000
`define EFLG_RESP_OKAY 2'h0
`define EFLG_RESP_SLVERR 2'h2
`endif

// file: verilog/eflg_pkg.sv
// Types shared by the event flag block
package eflg_pkg;
	typedef enum logic [1:0] {
		EFLG_WAKE = 2'b01,
		EFLG_SLEEP = 2'b10
	} eflg_state_t;
	typedef struct packed {
		logic [1:0] wake_power_setting;
		logic [3:0] wake_odr;
		logic [1:0] sleep_power_setting;
		logic [3:0] sleep_odr;
		logic [3:0] wake_decim;
		logic [3:0] wake_idle;
		logic [3:0] sleep_decim;
		logic [3:0] sleep_idle;
	} eflg_perf_t;
endpackage

// file: verilog/eflg_read_if.sv
// Read strobes and cleared bits between the bus slave and the flag core
`timescale 1ns/1ps
`default_nettype none
interface eflg_read_if;
	logic rd_src1;
	logic rd_src2;
	logic rd_orient;
	logic rd_sysmode;
	logic outside_threshold_event_flag;
	logic within_threshold_event_flag;
	logic orientation_change_flag;
	logic wake_sleep_transition_flag;
	logic sleep_now;
	logic last_to_sleep;
	modport core (input rd_src1, rd_src2, rd_orient, rd_sysmode,
		output outside_threshold_event_flag, within_threshold_event_flag,
		orientation_change_flag, wake_sleep_transition_flag, sleep_now, last_to_sleep);
	modport bus (output rd_src1, rd_src2, rd_orient, rd_sysmode,
		input outside_threshold_event_flag, within_threshold_event_flag,
		orientation_change_flag, wake_sleep_transition_flag, sleep_now, last_to_sleep);
endinterface
`default_nettype wire

// file: verilog/eflg_core.sv
// Flag core: status bits 4 to 1 and the inactivity wake/sleep machine
`timescale 1ns/1ps
`default_nettype none
`include "eflg_defines.svh"
module eflg_core
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// Sources
	input wire logic outside_event_active,
	input wire logic within_event_active,
	input wire logic new_orientation_indicator,
	input wire logic orient_change,
	input wire logic odr_tick,
	input wire logic any_event,
	// Settings
	input wire logic outside_event_latch_enable,
	input wire logic within_event_latch_enable,
	input wire logic wake_sleep_interrupt_enable,
	input wire logic [15:0] inactivity_count,
	// Strobes and flags
	eflg_read_if.core rif
);
	logic ot_reg;
	logic wt_reg;
	logic or_reg;
	logic as_reg;
	logic st_reg;
	logic dir_reg;
	logic [15:0] idle_reg;
	logic auto_en;
	logic go_sleep;
	logic go_wake;

	assign auto_en = (inactivity_count != 16'h0000);
	assign go_sleep = auto_en && !st_reg && odr_tick && !any_event
		&& (idle_reg + 16'h0001 >= inactivity_count);
	assign go_wake = auto_en && st_reg && any_event;

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			ot_reg <= 1'b0;
		else if (ce)
		begin
			if (outside_event_active)
				ot_reg <= 1'b1;
			else if (!outside_event_latch_enable || rif.rd_src1)
				ot_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			wt_reg <= 1'b0;
		else if (ce)
		begin
			if (within_event_active)
				wt_reg <= 1'b1;
			else if (!within_event_latch_enable || rif.rd_src2)
				wt_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			or_reg <= 1'b0;
		else if (ce)
		begin
			if (new_orientation_indicator && orient_change)
				or_reg <= 1'b1;
			else if (rif.rd_orient)
				or_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			idle_reg <= 16'h0000;
			st_reg <= 1'b0;
			dir_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (!auto_en)
			begin
				idle_reg <= 16'h0000;
				st_reg <= 1'b0;
			end
			else if (any_event)
				idle_reg <= 16'h0000;
			else if (odr_tick && !st_reg)
				idle_reg <= idle_reg + 16'h0001;
			if (go_sleep)
			begin
				st_reg <= 1'b1;
				dir_reg <= 1'b1;
				idle_reg <= 16'h0000;
			end
			else if (go_wake)
			begin
				st_reg <= 1'b0;
				dir_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			as_reg <= 1'b0;
		else if (ce)
		begin
			if (!auto_en || !wake_sleep_interrupt_enable)
				as_reg <= 1'b0;
			else if (go_sleep || go_wake)
				as_reg <= 1'b1;
			else if (rif.rd_sysmode)
				as_reg <= 1'b0;
		end
	end

	assign rif.outside_threshold_event_flag = ot_reg;
	assign rif.within_threshold_event_flag = wt_reg;
	assign rif.orientation_change_flag = or_reg;
	assign rif.wake_sleep_transition_flag = as_reg;
	assign rif.sleep_now = st_reg;
	assign rif.last_to_sleep = dir_reg;
endmodule
`default_nettype wire

// file: verification/eflg_host.sv
// AXI4-Lite host model that reaches the event flag registers
`timescale 1ns/1ps
`default_nettype none
module eflg_host
(
	// Clock
	input wire logic clk_sys,
	// Write channels
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// Slow host raises ready only after the answer shows
	logic slow = 1'h0;
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= !slow;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && !s_axi_bready)
				s_axi_bready <= 1'h1;
		end
		while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		// Released lines must not keep the old value
		s_axi_awaddr <= ~a;
		s_axi_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= !slow;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && !s_axi_rready)
				s_axi_rready <= 1'h1;
		end
		while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		s_axi_araddr <= ~a;
	endtask
endmodule
`default_nettype wire

// file: verification/eflg_chk.sv
// Concurrent checks on the event flag block ports
`timescale 1ns/1ps
`default_nettype none
`include "eflg_defines.svh"
module eflg_chk
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Sources and settings
	input wire logic any_event,
	input wire eflg_pkg::eflg_perf_t perf_cfg,
	// Bus
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Applied settings
	input wire logic [1:0] power_setting,
	input wire logic [3:0] output_data_rate,
	input wire logic sleep_active
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// Settings are judged only once reset values have passed
	logic [1:0] up_reg;
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
		else $error("read not answered");
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	chk_rresp_code: assert property (s_axi_rvalid
		|-> s_axi_rresp == `EFLG_RESP_OKAY || s_axi_rresp == `EFLG_RESP_SLVERR)
		else $error("bad read response code");
	chk_sleep_cfg: assert property (up_reg == 2'h3 && sleep_active && $past(sleep_active)
		|-> power_setting == perf_cfg.sleep_power_setting
		&& output_data_rate == perf_cfg.sleep_odr)
		else $error("sleep settings not applied");
	chk_wake_cfg: assert property (up_reg == 2'h3 && !sleep_active && !$past(sleep_active)
		|-> power_setting == perf_cfg.wake_power_setting
		&& output_data_rate == perf_cfg.wake_odr)
		else $error("wake settings not applied");
	chk_event_wake: assert property (sleep_active && any_event |-> ##[1:3] !sleep_active)
		else $error("event did not wake");
endmodule
bind eflg_top eflg_chk chk_u (.clk_sys, .arst_n, .any_event, .perf_cfg, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_setting, .output_data_rate, .sleep_active);
`default_nettype wire

// file: verification/eflg_top_tb.sv
// Self-checking bench of the event flag block
`timescale 1ns/1ps
`default_nettype none
`include "eflg_defines.svh"
`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("BAD %0t got %0h want %0h", $time, g, e); \
		end \
	end
module eflg_top_tb;
	logic clk_sys = 1'h0;
	logic arst_n = 1'h0;
	logic outside_event_active = 1'h0;
	logic within_event_active = 1'h0;
	logic new_orientation_indicator = 1'h0;
	logic orient_change = 1'h0;
	logic odr_tick = 1'h0;
	logic any_event = 1'h0;
	logic ce = 1'h1;
	eflg_pkg::eflg_perf_t perf_cfg = {2'h1, 4'h5, 2'h2, 4'h9, 4'h3, 4'h4, 4'h6, 4'h7};
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, decim_setting, idle_setting, output_data_rate;
	logic [1:0] s_axi_bresp, s_axi_rresp, power_setting, rr, pat;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_active, irq;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Rows: outside source, within source, expected status bits 4..1
	logic [5:0] tbl [5] = '{6'h00, 6'h28, 6'h3C, 6'h14, 6'h00};
	eflg_top dut_u (.clk_sys, .arst_n, .ce, .outside_event_active, .within_event_active,
		.new_orientation_indicator, .orient_change, .odr_tick, .any_event, .perf_cfg,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_setting,
		.output_data_rate, .decim_setting, .idle_setting, .sleep_active, .irq);
	eflg_host host_u (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	always #12.5 clk_sys = ~clk_sys;
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Data periods, then three settling cycles
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			odr_tick <= 1'h1;
			@(posedge clk_sys);
			odr_tick <= 1'h0;
		end
		repeat (3) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			test_done();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'h1;
		foreach (tbl[i])
		begin
			host_u.slow = i[0];
			@(posedge clk_sys);
			{outside_event_active, within_event_active} <= tbl[i][5:4];
			tick(0);
			host_u.rd(`EFLG_OFF_STATUS, rv, rr);
			`CHK(rv[4:1], tbl[i][3:0])
		end
		$display("table done");
		host_u.wr(`EFLG_OFF_CTRL, 32'h0000_0003, rr);
		for (int i = 0; i < 2; i++)
		begin
			pat = 2'h2 >> i;
			{outside_event_active, within_event_active} <= pat;
			tick(0);
			{outside_event_active, within_event_active} <= 2'h0;
			tick(0);
			host_u.rd(`EFLG_OFF_STATUS, rv, rr);
			`CHK(rv[4:3], pat)
			host_u.rd(`EFLG_OFF_SRC1 + 8'(i * 4), rv, rr);
			`CHK(rv[0], 1'h1)
			host_u.rd(`EFLG_OFF_STATUS, rv, rr);
			`CHK(rv[4:3], 2'h0)
		end
		$display("latch done");
		new_orientation_indicator <= 1'h1;
		tick(0);
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[2], 1'h0)
		orient_change <= 1'h1;
		tick(0);
		{new_orientation_indicator, orient_change} <= 2'h0;
		tick(0);
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[2], 1'h1)
		host_u.rd(`EFLG_OFF_ORIENT, rv, rr);
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[2], 1'h0)
		$display("orientation done");
		host_u.wr(`EFLG_OFF_CTRL, 32'h0000_0000, rr);
		host_u.wr(`EFLG_OFF_IRQMASK, 32'h0000_0010, rr);
		host_u.wr(`EFLG_OFF_IRQ, 32'h0000_001E, rr);
		outside_event_active <= 1'h1;
		tick(0);
		@(posedge clk_sys);
		`CHK(irq, 1'h1)
		outside_event_active <= 1'h0;
		host_u.wr(`EFLG_OFF_IRQ, 32'h0000_0010, rr);
		within_event_active <= 1'h1;
		tick(0);
		within_event_active <= 1'h0;
		`CHK(irq, 1'h0)
		host_u.rd(`EFLG_OFF_IRQ, rv, rr);
		`CHK(rv[4:1], 4'h4)
		$display("interrupt done");
		host_u.wr(`EFLG_OFF_COUNT, 32'h0000_0003, rr);
		host_u.wr(`EFLG_OFF_CTRL, 32'h0000_000C, rr);
		tick(2);
		`CHK(sleep_active, 1'h0)
		tick(1);
		`CHK(sleep_active, 1'h1)
		`CHK(power_setting, perf_cfg.sleep_power_setting)
		`CHK(decim_setting, perf_cfg.sleep_decim)
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[1], 1'h1)
		host_u.rd(`EFLG_OFF_SYSMODE, rv, rr);
		`CHK(rv[1:0], 2'h3)
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[1], 1'h0)
		any_event <= 1'h1;
		@(posedge clk_sys);
		any_event <= 1'h0;
		tick(0);
		`CHK(output_data_rate, perf_cfg.wake_odr)
		`CHK(idle_setting, perf_cfg.wake_idle)
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[1], 1'h1)
		host_u.rd(`EFLG_OFF_SYSMODE, rv, rr);
		`CHK(rv[1:0], 2'h0)
		host_u.wr(`EFLG_OFF_CTRL, 32'h0000_0008, rr);
		tick(3);
		`CHK(sleep_active, 1'h1)
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[1], 1'h0)
		arst_n <= 1'h0;
		tick(0);
		`CHK(sleep_active, 1'h0)
		arst_n <= 1'h1;
		host_u.wr(`EFLG_OFF_CTRL, 32'h0000_000C, rr);
		tick(5);
		`CHK(sleep_active, 1'h0)
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[1], 1'h0)
		host_u.wr(`EFLG_OFF_COUNT, 32'h0000_0003, rr);
		ce <= 1'h0;
		tick(3);
		`CHK(sleep_active, 1'h0)
		ce <= 1'h1;
		tick(3);
		`CHK(sleep_active, 1'h1)
		host_u.rd(`EFLG_OFF_SYSMODE, rv, rr);
		`CHK(rv[1:0], 2'h3)
		$display("wake sleep done");
		host_u.rd(8'h40, rv, rr);
		`CHK({rr, rv}, {`EFLG_RESP_SLVERR, 32'h0000_0000})
		host_u.wr(`EFLG_OFF_STATUS, 32'h0000_001E, rr);
		`CHK(rr, `EFLG_RESP_OKAY)
		host_u.rd(`EFLG_OFF_STATUS, rv, rr);
		`CHK(rv[4:1], 4'h0)
		$display("bus done");
		test_done();
	end
endmodule
`default_nettype wire
